// ===== verilog/flow_ctl_pkg.sv
// constants, register map and types for the per-port flow control block
// assumes a 40 MHz core clock and a 32-bit AXI4-Lite register slave
package flow_ctl_pkg;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_STA_LO = 8'h00;
	localparam logic [7:0] IDX_STA_HI = 8'h01;
	localparam logic [7:0] IDX_TX_QUANTA = 8'h07;
	localparam logic [7:0] IDX_FC_EN = 8'h12;
	localparam logic [7:0] IDX_HI_WM = 8'h20;
	localparam logic [7:0] IDX_LO_WM = 8'h21;
	localparam logic [7:0] IDX_THRESH = 8'h22;
	localparam logic [7:0] IDX_MODE = 8'h23;
	localparam logic [7:0] IDX_RX_FAIL = 8'h24;
	localparam logic [7:0] IDX_TX_FAIL = 8'h25;
	localparam logic [7:0] IDX_STATUS = 8'h26;

	// ==========================================================
	// reset values and field positions
	localparam logic [15:0] TX_QUANTA_RST = 16'h005E;
	localparam logic [2:0] FC_EN_RST = 3'h0;
	localparam logic [15:0] HI_WM_RST = 16'h0C00;
	localparam logic [15:0] LO_WM_RST = 16'h0400;
	localparam logic [15:0] THRESH_RST = 16'h0010;
	localparam logic [3:0] MODE_RST = 4'h2;
	localparam int FC_RX_BIT = 0;
	localparam int FC_TX_BIT = 1;
	localparam int FC_HD_BIT = 2;
	localparam int MODE_HALF_BIT = 2;
	localparam int MODE_PASS_BIT = 3;
	localparam logic [1:0] SPD_10M = 2'h0;
	localparam logic [1:0] SPD_100M = 2'h1;
	localparam logic [1:0] SPD_1G = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// frame layout
	localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam logic [4:0] HDR_DA_END = 5'h06;
	localparam logic [4:0] HDR_TYPE = 5'h0C;
	localparam logic [4:0] HDR_OP = 5'h0E;
	localparam logic [4:0] HDR_QUANTA = 5'h10;
	localparam logic [4:0] HDR_SAT = 5'h1F;
	localparam logic [5:0] GEN_FCS = 6'h3C;
	localparam logic [5:0] GEN_LAST = 6'h3F;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;

	// ==========================================================
	// one pause quantum (512 bit times) in core cycles, rounded down
	localparam int CLK_MHZ = 40;
	localparam int QUANTUM_NS_1G = 512;
	localparam int QUANTUM_NS_100M = 5120;
	localparam int QUANTUM_NS_10M = 51200;
	localparam logic [11:0] QCYC_1G = 12'((QUANTUM_NS_1G * CLK_MHZ) / 1000);
	localparam logic [11:0] QCYC_100M = 12'((QUANTUM_NS_100M * CLK_MHZ) / 1000);
	localparam logic [11:0] QCYC_10M = 12'((QUANTUM_NS_10M * CLK_MHZ) / 1000);

	// ==========================================================
	// external request codes and generator states
	localparam logic [2:0] REQ_XON = 3'h0;
	localparam logic [2:0] REQ_ALL = 3'h7;
	typedef enum logic {GEN_IDLE = 1'b0, GEN_SEND = 1'b1} gen_state_t;

endpackage : flow_ctl_pkg

// ===== verilog/flow_ctl_port.sv
// one port of flow control: frame check, pause generation and response
// assumes rx/tx byte streams on clk_i, async pause request pins
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module flow_ctl_port import flow_ctl_pkg::*; #(
	parameter int AW = 10,
	parameter int LW = 16,
	parameter logic [2:0] PORT_ID = 3'h0
) (
	input wire logic clk_i, // core clock 40 MHz
	input wire logic sys_rst_i, // async reset, high
	input wire logic [AW-1:0] s_axi_awaddr_i, // write address
	input wire logic s_axi_awvalid_i, // write address valid
	output logic s_axi_awready_o, // write address ready
	input wire logic [31:0] s_axi_wdata_i, // write data
	input wire logic [3:0] s_axi_wstrb_i, // byte strobes
	input wire logic s_axi_wvalid_i, // write data valid
	output logic s_axi_wready_o, // write data ready
	output logic [1:0] s_axi_bresp_o, // write response
	output logic s_axi_bvalid_o, // write response valid
	input wire logic s_axi_bready_i, // write response ready
	input wire logic [AW-1:0] s_axi_araddr_i, // read address
	input wire logic s_axi_arvalid_i, // read address valid
	output logic s_axi_arready_o, // read address ready
	output logic [31:0] s_axi_rdata_o, // read data
	output logic [1:0] s_axi_rresp_o, // read response
	output logic s_axi_rvalid_o, // read data valid
	input wire logic s_axi_rready_i, // read data ready
	input wire logic rx_valid_i, // receive byte valid
	input wire logic rx_sof_i, // first byte of frame
	input wire logic rx_eof_i, // last byte of frame
	input wire logic [7:0] rx_data_i, // receive byte
	input wire logic [LW-1:0] rx_fifo_level_i, // receive fifo fill
	output logic rx_drop_o, // mark frame for drop
	input wire logic tx_valid_i, // transmit byte valid
	input wire logic tx_sof_i, // first transmit byte
	input wire logic tx_eof_i, // last transmit byte
	input wire logic [7:0] tx_data_i, // transmit byte
	output logic tx_halt_o, // hold off next frame
	output logic pause_valid_o, // pause frame byte valid
	input wire logic pause_ready_i, // transmitter takes byte
	output logic pause_last_o, // last pause frame byte
	output logic [7:0] pause_data_o, // pause frame byte
	output logic force_collision_o, // collide current rx packet
	input wire logic [2:0] pause_request_select_i, // async request code
	input wire logic pause_request_strobe_i // async request strobe
);

	// ==========================================================
	// state
	typedef struct packed {
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] sta_lo;
		logic [31:0] sta_hi;
		logic [15:0] quanta;
		logic [2:0] fc_en;
		logic [LW-1:0] hi_wm;
		logic [LW-1:0] lo_wm;
		logic [15:0] thresh;
		logic [3:0] mode;
		logic [31:0] rx_fail;
		logic [31:0] tx_fail;
		logic [31:0] rx_crc;
		logic [31:0] tx_crc;
		logic [4:0] rx_idx;
		logic [47:0] rx_da;
		logic [15:0] rx_type;
		logic [15:0] rx_op;
		logic [15:0] rx_q;
		logic rx_drop;
		logic tx_busy;
		logic [11:0] qdiv;
		logic [15:0] rx_pq;
		logic halt;
		logic flow;
		logic [15:0] refresh;
		logic pend;
		logic [15:0] pend_q;
		gen_state_t gen;
		logic [5:0] gen_idx;
		logic [15:0] gen_q;
		logic [31:0] gen_crc;
		logic [7:0] gen_data;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic strobe_d;
		logic collide;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic tick;
	logic ext_go;
	logic gen_ok;
	logic rx_bad;
	logic tx_bad;
	logic rx_pause_ok;

	// reflected crc-32, one byte
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] x;
		x = c ^ {24'h00_0000, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_step

	// byte n of a pause frame; tail past the header is zero pad, then fcs
	function automatic logic [7:0] gen_byte(input logic [5:0] n, input logic [47:0] sa,
			input logic [15:0] q, input logic [31:0] c);
		logic [31:0] f;
		f = ~c;
		case (n)
			6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05: gen_byte = PAUSE_DA[8'(6'h2F - 6'(n * 8)) -: 8];
			6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B: gen_byte = sa[8'(6'h2F - 6'((n - 6) * 8)) -: 8];
			6'h0C: gen_byte = PAUSE_TYPE[15:8];
			6'h0D: gen_byte = PAUSE_TYPE[7:0];
			6'h0E: gen_byte = PAUSE_OPCODE[15:8];
			6'h0F: gen_byte = PAUSE_OPCODE[7:0];
			6'h10: gen_byte = q[15:8];
			6'h11: gen_byte = q[7:0];
			6'h3C: gen_byte = f[7:0];
			6'h3D: gen_byte = f[15:8];
			6'h3E: gen_byte = f[23:16];
			6'h3F: gen_byte = f[31:24];
			default: gen_byte = 8'h00;
		endcase
	endfunction : gen_byte

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				o[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return o;
	endfunction : merge

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] c;
		logic [31:0] rd;
		logic rd_ok;
		logic [11:0] qlim;
		logic [7:0] ri;
		logic [47:0] sa;
		logic pause_fmt;
		c = CRC_INIT;
		rd = 32'h0000_0000;
		rd_ok = 1'b1;
		qlim = QCYC_10M;
		ri = 8'(s_axi_araddr_i >> 2);
		sa = {st_r.sta_hi[15:0], st_r.sta_lo};
		pause_fmt = 1'b0;
		st_nxt = st_r;
		st_nxt.rx_drop = 1'b0;

		// register writes, address and data taken in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.aw_idx = 8'(s_axi_awaddr_i >> 2);
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			st_nxt.w_ok = 1'b1;
			st_nxt.wdata = s_axi_wdata_i;
			st_nxt.wstrb = s_axi_wstrb_i;
		end
		if (st_r.bvalid && s_axi_bready_i) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.aw_idx)
				IDX_STA_LO: st_nxt.sta_lo = merge(st_r.sta_lo, st_r.wdata, st_r.wstrb);
				IDX_STA_HI: st_nxt.sta_hi = merge(st_r.sta_hi, st_r.wdata, st_r.wstrb);
				IDX_TX_QUANTA: st_nxt.quanta = 16'(merge(32'(st_r.quanta), st_r.wdata, st_r.wstrb));
				IDX_FC_EN: st_nxt.fc_en = 3'(merge(32'(st_r.fc_en), st_r.wdata, st_r.wstrb));
				IDX_HI_WM: st_nxt.hi_wm = LW'(merge(32'(st_r.hi_wm), st_r.wdata, st_r.wstrb));
				IDX_LO_WM: st_nxt.lo_wm = LW'(merge(32'(st_r.lo_wm), st_r.wdata, st_r.wstrb));
				IDX_THRESH: st_nxt.thresh = 16'(merge(32'(st_r.thresh), st_r.wdata, st_r.wstrb));
				IDX_MODE: st_nxt.mode = 4'(merge(32'(st_r.mode), st_r.wdata, st_r.wstrb));
				IDX_RX_FAIL, IDX_TX_FAIL, IDX_STATUS: st_nxt.bresp = RESP_OKAY; // read only
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end

		// register reads, answered one cycle after the address is taken
		case (ri)
			IDX_STA_LO: rd = st_r.sta_lo;
			IDX_STA_HI: rd = st_r.sta_hi;
			IDX_TX_QUANTA: rd = 32'(st_r.quanta);
			IDX_FC_EN: rd = 32'(st_r.fc_en);
			IDX_HI_WM: rd = 32'(st_r.hi_wm);
			IDX_LO_WM: rd = 32'(st_r.lo_wm);
			IDX_THRESH: rd = 32'(st_r.thresh);
			IDX_MODE: rd = 32'(st_r.mode);
			IDX_RX_FAIL: rd = st_r.rx_fail;
			IDX_TX_FAIL: rd = st_r.tx_fail;
			IDX_STATUS: rd = {12'h000, st_r.collide, st_r.gen, st_r.halt, st_r.flow, st_r.rx_pq};
			default: rd_ok = 1'b0;
		endcase
		if (st_r.rvalid && s_axi_rready_i) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd;
			st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// pause quantum divider follows the link speed
		case (st_r.mode[1:0])
			SPD_1G: qlim = QCYC_1G;
			SPD_100M: qlim = QCYC_100M;
			default: qlim = QCYC_10M;
		endcase
		tick = st_r.qdiv >= qlim - 12'h001;
		st_nxt.qdiv = tick ? 12'h000 : st_r.qdiv + 12'h001;

		// receive parse and checksum
		rx_bad = 1'b0;
		rx_pause_ok = 1'b0;
		if (rx_valid_i) begin
			c = crc_step(rx_sof_i ? CRC_INIT : st_r.rx_crc, rx_data_i);
			st_nxt.rx_crc = c;
			if (rx_sof_i) begin
				st_nxt.rx_idx = 5'h01;
				st_nxt.rx_da = {40'h00_0000_0000, rx_data_i};
			end else begin
				if (st_r.rx_idx != HDR_SAT) begin
					st_nxt.rx_idx = st_r.rx_idx + 5'h01;
				end
				if (st_r.rx_idx < HDR_DA_END) begin
					st_nxt.rx_da = {st_r.rx_da[39:0], rx_data_i};
				end
				if (st_r.rx_idx[4:1] == HDR_TYPE[4:1]) begin
					st_nxt.rx_type = {st_r.rx_type[7:0], rx_data_i};
				end
				if (st_r.rx_idx[4:1] == HDR_OP[4:1]) begin
					st_nxt.rx_op = {st_r.rx_op[7:0], rx_data_i};
				end
				if (st_r.rx_idx[4:1] == HDR_QUANTA[4:1]) begin
					st_nxt.rx_q = {st_r.rx_q[7:0], rx_data_i};
				end
			end
			if (rx_eof_i) begin
				rx_bad = c != CRC_RESIDUE;
				pause_fmt = st_r.rx_type == PAUSE_TYPE && st_r.rx_op == PAUSE_OPCODE;
				rx_pause_ok = pause_fmt && !rx_bad && st_r.fc_en[FC_RX_BIT]
					&& (st_r.rx_da == PAUSE_DA || st_r.rx_da == sa);
				st_nxt.rx_drop = pause_fmt && st_r.rx_da == PAUSE_DA
					&& st_r.fc_en[FC_RX_BIT] && !st_r.mode[MODE_PASS_BIT];
				if (rx_bad) begin
					st_nxt.rx_fail = st_r.rx_fail + 32'h0000_0001;
				end
			end
		end

		// received pause countdown, zero quanta releases at once
		if (rx_pause_ok) begin
			st_nxt.rx_pq = st_r.rx_q;
		end else if (tick && st_r.rx_pq != 16'h0000) begin
			st_nxt.rx_pq = st_r.rx_pq - 16'h0001;
		end

		// transmit monitor; halt only rises between frames
		tx_bad = 1'b0;
		if (tx_valid_i) begin
			c = crc_step(tx_sof_i ? CRC_INIT : st_r.tx_crc, tx_data_i);
			st_nxt.tx_crc = c;
			if (tx_sof_i) begin
				st_nxt.tx_busy = 1'b1;
			end
			if (tx_eof_i) begin
				st_nxt.tx_busy = 1'b0;
				tx_bad = c != CRC_RESIDUE;
				if (tx_bad) begin
					st_nxt.tx_fail = st_r.tx_fail + 32'h0000_0001;
				end
			end
		end
		st_nxt.halt = st_nxt.rx_pq != 16'h0000
			&& (st_r.halt || !(st_r.tx_busy || (tx_valid_i && tx_sof_i)));

		// pause generator takes the pending request when idle
		if (st_r.gen == GEN_IDLE && st_r.pend) begin
			st_nxt.pend = 1'b0;
			st_nxt.gen = GEN_SEND;
			st_nxt.gen_idx = 6'h00;
			st_nxt.gen_q = st_r.pend_q;
			st_nxt.gen_crc = CRC_INIT;
			st_nxt.gen_data = gen_byte(6'h00, sa, st_r.pend_q, CRC_INIT);
		end else if (st_r.gen == GEN_SEND && pause_ready_i) begin
			c = st_r.gen_idx < GEN_FCS ? crc_step(st_r.gen_crc, st_r.gen_data) : st_r.gen_crc;
			st_nxt.gen_crc = c;
			if (st_r.gen_idx == GEN_LAST) begin
				st_nxt.gen = GEN_IDLE;
			end else begin
				st_nxt.gen_idx = st_r.gen_idx + 6'h01;
				st_nxt.gen_data = gen_byte(st_r.gen_idx + 6'h01, sa, st_r.gen_q, c);
			end
		end

		// watermark hysteresis; refresh timer counts in quanta
		if (rx_fifo_level_i >= st_r.hi_wm) begin
			st_nxt.flow = 1'b1;
		end else if (rx_fifo_level_i < st_r.lo_wm) begin
			st_nxt.flow = 1'b0;
		end
		if (tick && st_r.refresh != 16'h0000) begin
			st_nxt.refresh = st_r.refresh - 16'h0001;
		end
		gen_ok = st_r.fc_en[FC_TX_BIT] && !st_r.mode[MODE_HALF_BIT];
		if (gen_ok) begin
			if (st_nxt.flow && (!st_r.flow || st_r.refresh <= st_r.thresh)) begin
				st_nxt.pend = 1'b1;
				st_nxt.pend_q = st_r.quanta;
				st_nxt.refresh = st_r.quanta;
			end else if (st_r.flow && !st_nxt.flow) begin
				st_nxt.pend = 1'b1;
				st_nxt.pend_q = 16'h0000;
			end
		end

		// external request pins, decoded after synchronisation
		st_nxt.sync1 = {pause_request_strobe_i, pause_request_select_i};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.strobe_d = st_r.sync2[3];
		ext_go = st_r.sync2[3] && !st_r.strobe_d && st_r.fc_en[FC_TX_BIT];
		if (ext_go) begin
			if (st_r.sync2[2:0] == REQ_XON) begin
				st_nxt.pend = 1'b1;
				st_nxt.pend_q = 16'h0000;
			end else if (st_r.sync2[2:0] == REQ_ALL || st_r.sync2[2:0] == PORT_ID + 3'h1) begin
				st_nxt.pend = 1'b1;
				st_nxt.pend_q = st_r.quanta;
			end
		end

		// half duplex back-pressure decided at packet start only
		if (rx_valid_i && rx_sof_i) begin
			st_nxt.collide = st_r.mode[MODE_HALF_BIT] && st_r.fc_en[FC_HD_BIT] && st_r.flow;
		end else if (rx_valid_i && rx_eof_i) begin
			st_nxt.collide = 1'b0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
			st_r.quanta <= TX_QUANTA_RST;
			st_r.fc_en <= FC_EN_RST;
			st_r.hi_wm <= LW'(HI_WM_RST);
			st_r.lo_wm <= LW'(LO_WM_RST);
			st_r.thresh <= THRESH_RST;
			st_r.mode <= MODE_RST;
			st_r.rx_crc <= CRC_INIT;
			st_r.tx_crc <= CRC_INIT;
			st_r.gen <= GEN_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs; bus handshakes combinational, data from flops
	assign s_axi_awready_o = !st_r.aw_ok && !st_r.bvalid;
	assign s_axi_wready_o = !st_r.w_ok && !st_r.bvalid;
	assign s_axi_bvalid_o = st_r.bvalid;
	assign s_axi_bresp_o = st_r.bresp;
	assign s_axi_arready_o = !st_r.rvalid;
	assign s_axi_rvalid_o = st_r.rvalid;
	assign s_axi_rdata_o = st_r.rdata;
	assign s_axi_rresp_o = st_r.rresp;
	assign rx_drop_o = st_r.rx_drop;
	assign tx_halt_o = st_r.halt;
	assign pause_valid_o = st_r.gen == GEN_SEND;
	assign pause_last_o = st_r.gen == GEN_SEND && st_r.gen_idx == GEN_LAST;
	assign pause_data_o = st_r.gen_data;
	assign force_collision_o = st_r.collide;

	// ==========================================================
	// checks
	a_rx_fail_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rx_bad |=> st_r.rx_fail == $past(st_r.rx_fail) + 32'h0000_0001)
		else $error("rx check failure not counted");
	a_tx_fail_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!tx_bad |=> st_r.tx_fail == $past(st_r.tx_fail))
		else $error("tx failure count moved without a bad frame");
	a_high_halts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		gen_ok && !st_r.flow && rx_fifo_level_i >= st_r.hi_wm && !ext_go
		|=> st_r.pend && st_r.pend_q == $past(st_r.quanta))
		else $error("high watermark did not request a halt frame");
	a_low_resumes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		gen_ok && st_r.flow && rx_fifo_level_i < st_r.lo_wm && !ext_go
		|=> st_r.pend && st_r.pend_q == 16'h0000)
		else $error("low watermark did not request a resume frame");
	a_frame_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(pause_valid_o) |-> pause_data_o == PAUSE_DA[47:40] && st_r.gen_idx == 6'h00)
		else $error("pause frame did not start with reserved address");
	a_rx_pause_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rx_pause_ok |=> st_r.rx_pq == $past(st_r.rx_q))
		else $error("received pause quanta not loaded");
	a_no_truncate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		st_r.tx_busy && !st_r.halt |=> !tx_halt_o)
		else $error("halt raised inside a transmit frame");
	a_ext_xon: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ext_go && st_r.sync2[2:0] == REQ_XON |=> st_r.pend && st_r.pend_q == 16'h0000)
		else $error("code zero did not request a resume frame");
	a_ext_all: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ext_go && st_r.sync2[2:0] == REQ_ALL |=> st_r.pend && st_r.pend_q == $past(st_r.quanta))
		else $error("code seven did not request a halt frame");
	a_new_collide: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rx_valid_i && rx_sof_i && st_r.mode[MODE_HALF_BIT] && st_r.fc_en[FC_HD_BIT] && st_r.flow
		|=> force_collision_o)
		else $error("flow state did not collide new packet");
	a_countdown: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		tick && st_r.rx_pq != 16'h0000 && !rx_pause_ok
		|=> st_r.rx_pq == $past(st_r.rx_pq) - 16'h0001)
		else $error("pause countdown did not step");

endmodule : flow_ctl_port

// ===== verification/link_partner.sv
// link partner sink for generated pause frames, plus pause request controller
// assumes the port's pause byte stream runs on the core clock
`timescale 1ns/1ps
module link_partner (
	input wire logic clk_i, // core clock
	input wire logic valid_i, // pause byte valid
	input wire logic last_i, // last pause byte
	input wire logic [7:0] data_i, // pause byte
	output logic ready_o, // byte taken
	output logic [2:0] sel_o, // request code
	output logic strobe_o, // request strobe
	output logic [15:0] quanta_o, // quanta of last frame
	output logic [7:0] len_o, // length of last frame
	output int frames_o // frames seen
);
	logic [7:0] n = 0;
	initial {ready_o, sel_o, strobe_o, quanta_o, len_o, frames_o} = '0;
	// ==========================================
	// sink: stalls at random, like a busy transmitter
	always @(posedge clk_i) begin
		ready_o <= ($urandom % 4) != 0;
		if (valid_i && ready_o) begin
			n <= last_i ? 8'h00 : n + 8'h01;
			if (n == 16 || n == 17) quanta_o <= {quanta_o[7:0], data_i};
			if (last_i) len_o <= n + 8'h01;
			if (last_i) frames_o <= frames_o + 1;
		end
	end
	// ==========================================
	// controller: code first, strobe later, no clock; reserved codes never sent
	// small offset first: callers return on a clock edge, pins must not move there
	task automatic request(input logic [2:0] code);
		#5 sel_o = code;
		#37 strobe_o = 1;
		#113 strobe_o = 0;
		#90;
	endtask : request
endmodule : link_partner

// ===== verification/testbench.sv
// self-checking bench for one flow control port
// assumes the link partner model and the port's package
`timescale 1ns/1ps
module testbench import flow_ctl_pkg::*;;
	typedef logic [7:0] bq_t[$];
	logic clk_i = 0, sys_rst_i = 1, awv = 0, wv = 0, arv = 0;
	logic [9:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic rxv = 0, rxs = 0, rxe = 0, txv = 0, txs = 0, txe = 0;
	logic [7:0] rxd = 0, txd = 0, pd, len;
	logic [15:0] level = 0, quanta;
	logic awready, wready, bvalid, arready, rvalid, drop, halt, pv, pr, pl, coll, stb;
	logic [1:0] bresp, rresp, br;
	logic [2:0] sel;
	logic [31:0] rdata;
	int frames, drops = 0, n_errors = 0, checks_done = 0, colls = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (drop === 1'b1) drops++;
	always @(posedge clk_i) if (coll === 1'b1) colls++;
	flow_ctl_port dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(1'b1), .rx_valid_i(rxv), .rx_sof_i(rxs), .rx_eof_i(rxe),
		.rx_data_i(rxd), .rx_fifo_level_i(level), .rx_drop_o(drop), .tx_valid_i(txv),
		.tx_sof_i(txs), .tx_eof_i(txe), .tx_data_i(txd), .tx_halt_o(halt),
		.pause_valid_o(pv), .pause_ready_i(pr), .pause_last_o(pl), .pause_data_o(pd),
		.force_collision_o(coll), .pause_request_select_i(sel),
		.pause_request_strobe_i(stb));
	link_partner lp (.clk_i(clk_i), .valid_i(pv), .last_i(pl), .data_i(pd), .ready_o(pr),
		.sel_o(sel), .strobe_o(stb), .quanta_o(quanta), .len_o(len), .frames_o(frames));
	// ==========================================
	// verdict and comparisons
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) n_errors++;
		if (seen !== exp) $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
	endtask : check
	task automatic bound(input int k, input int lim);
		if (k >= lim) n_errors++;
		if (k >= lim) $display("[FAIL] %0t wait ran out", $time);
		if (k >= lim) summarize();
	endtask : bound
	// ==========================================
	// register bus; readies sampled mid-cycle so the edge decides nothing by race
	task automatic wr(input logic [7:0] ix, input logic [31:0] d);
		int k;
		logic a, w, b;
		awaddr <= {ix, 2'b00};
		wdata <= d;
		awv <= 1;
		wv <= 1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk_i) {a, w, b, br} = {awready, wready, bvalid, bresp};
			@(posedge clk_i) if (a) awv <= 0;
			if (w) wv <= 0;
			if (b) break;
		end
		bound(k, 50);
	endtask : wr
	task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] r);
		int k;
		logic a, v;
		araddr <= {ix, 2'b00};
		arv <= 1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk_i) {a, v, d, r} = {arready, rvalid, rdata, rresp};
			@(posedge clk_i) if (a) arv <= 0;
			if (v) break;
		end
		bound(k, 50);
	endtask : rd
	// ==========================================
	// frame streams; checksum appended low byte first, bad flips one bit
	function automatic logic [31:0] crc(input bq_t q);
		logic [31:0] c = CRC_INIT;
		foreach (q[i]) begin
			c ^= {24'h0, q[i]};
			repeat (8) c = (c >> 1) ^ (c[0] ? CRC_POLY : 32'h0);
		end
		return ~c;
	endfunction : crc
	function automatic bq_t pframe(input logic [47:0] da, input logic [15:0] qn);
		bq_t q;
		logic [143:0] h = {da, 48'h0, PAUSE_TYPE, PAUSE_OPCODE, qn};
		for (int i = 17; i >= 0; i--) q.push_back(h[8*i +: 8]);
		repeat (42) q.push_back(8'h00);
		return q;
	endfunction : pframe
	task automatic send(input bit t, input bq_t q, input bit bad);
		logic [31:0] c;
		c = crc(q) ^ {31'h0, bad};
		for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
		foreach (q[i]) begin
			if (t) {txv, txs, txe, txd} <= {1'b1, i == 0, i == q.size() - 1, q[i]};
			else {rxv, rxs, rxe, rxd} <= {1'b1, i == 0, i == q.size() - 1, q[i]};
			@(posedge clk_i);
		end
		if (t) txv <= 0;
		else rxv <= 0;
		repeat (4) @(posedge clk_i);
	endtask : send
	task automatic take_frame(output logic [15:0] qn);
		int k, f;
		f = frames;
		for (k = 0; k < 3000 && frames == f; k++) @(posedge clk_i);
		bound(k, 3000);
		check(len, 64);
		qn = quanta;
	endtask : take_frame
	task automatic wait_halt(input logic v, input int lim);
		for (int k = 0; k < lim && halt !== v; k++) @(posedge clk_i);
		check(halt, v);
	endtask : wait_halt
	// ==========================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] qn, got;
		logic [2:0] cd[3];
		bq_t q;
		cd = '{3'h1, 3'h0, 3'h7};
		void'($urandom(71461));
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
		rd(IDX_TX_QUANTA, d, r);
		check(d, 32'h0000_005E);
		rd(8'h30, d, r);
		check(r, RESP_SLVERR);
		wr(8'h30, 32'h0000_0000);
		check(br, RESP_SLVERR);
		lp.request(3'h1);
		repeat (200) @(posedge clk_i);
		check(frames, 0);
		$display("registers and disabled requests done");
		qn = 16'h0020 + 16'($urandom % 32);
		wr(IDX_FC_EN, 32'h0000_0003);
		check(br, RESP_OKAY);
		wr(IDX_TX_QUANTA, {16'h0, qn});
		foreach (cd[i]) begin
			lp.request(cd[i]);
			take_frame(got);
			check(got, cd[i] == 3'h0 ? 16'h0 : qn);
		end
		$display("external requests done");
		level <= HI_WM_RST;
		take_frame(got);
		check(got, qn);
		take_frame(got);
		check(got, qn);
		level <= LO_WM_RST - 16'h0001;
		take_frame(got);
		check(got, 0);
		$display("watermarks done");
		for (int t = 0; t < 2; t++) begin
			q = {};
			repeat (60) q.push_back(8'($urandom));
			send(t, q, 0);
			send(t, q, 1);
			rd(t ? IDX_TX_FAIL : IDX_RX_FAIL, d, r);
			check(d, 1);
		end
		$display("checksum counters done");
		send(0, pframe(PAUSE_DA, 16'h0003), 0);
		wait_halt(1, 10);
		// first quantum may be partial, so three quanta last at least 41 cycles
		repeat (30) @(posedge clk_i);
		check(halt, 1);
		wait_halt(0, 80);
		send(0, pframe(48'h0, 16'h0003), 0);
		wait_halt(1, 10);
		check(drops, 1);
		wait_halt(0, 80);
		wr(IDX_MODE, 32'h0000_000A);
		send(0, pframe(PAUSE_DA, 16'h0003), 0);
		wait_halt(1, 10);
		check(drops, 1);
		$display("received pause done");
		// pause arrives while a long frame is on the wire: halt waits for its end
		wait_halt(0, 80);
		q = {};
		repeat (100) q.push_back(8'($urandom));
		fork
			send(1, q, 0);
			begin
				send(0, pframe(PAUSE_DA, 16'h0010), 0);
				check(halt, 0);
			end
		join
		check(halt, 1);
		$display("no truncation done");
		// half duplex back-pressure on a new packet
		wr(IDX_MODE, 32'h0000_0006);
		wr(IDX_FC_EN, 32'h0000_0007);
		level <= HI_WM_RST;
		@(posedge clk_i);
		send(0, q, 0);
		check(colls > 0, 1);
		$display("collision done");
		summarize();
	end
endmodule : testbench
